// ==== cdi_regs.vh ====
/*
 Constants for the configuration data intake block: mode codes, widths,
 pin-vector positions and reset values.
 Assumes it is included by bare name from the design files only.
*/
`ifndef CDI_REGS_VH
`define CDI_REGS_VH

`define CDI_MODE_W        3
`define CDI_MODE_SSER     3'h0
`define CDI_MODE_MSER     3'h1
`define CDI_MODE_PERIPH   3'h2
`define CDI_MODE_MPAR     3'h3
`define CDI_MODE_EXPRESS  3'h4

`define CDI_BYTE_W        8
`define CDI_BYTE_MSB      7
`define CDI_BIT_CNT_W     3
`define CDI_BIT_LAST      3'h7
`define CDI_ADDR_W        18
`define CDI_ADDR_UP_W     4
`define CDI_FIFO_DEPTH    32

// Positions in the synchronised pin vector
`define CDI_PIN_W         14
`define CDI_PIN_CS_LO     0
`define CDI_PIN_CS_HI     1
`define CDI_PIN_WS        2
`define CDI_PIN_RS        3
`define CDI_PIN_CLK       4
`define CDI_PIN_DIN       5
`define CDI_PIN_D_LO      6
`define CDI_PIN_D_HI      12

`define CDI_STATUS_FILL   7'h7f
`define CDI_ZERO_BYTE     8'h00
`define CDI_ZERO_ADDR     18'h00000
`define CDI_ZERO_ADDR_UP  4'h0
`define CDI_ADDR_ONE      22'h000001

`endif

// ==== cdi_fifo.v ====
/*
 Byte buffer between the pin intake and the configuration frame loader.
 Assumes a single clock, an active-low asynchronous reset already
 synchronised, and a clock enable that freezes all state.
*/
`timescale 1ns/1ns
`default_nettype none
`include "cdi_regs.vh"

module cdi_fifo #(
   parameter WIDTH = `CDI_BYTE_W,
   parameter DEPTH = `CDI_FIFO_DEPTH,
   parameter AW    = 5
) (
   input  wire             i_clk,      // Block clock
   input  wire             i_rst_n,    // Synchronised reset, active low
   input  wire             i_ce,       // Clock enable
   input  wire             i_valid,    // Write request
   output wire             o_ready,    // Room for a word
   input  wire [WIDTH-1:0] i_data,     // Write data
   output reg              o_valid,    // Read data valid
   input  wire             i_ready,    // Reader takes the word
   output reg  [WIDTH-1:0] o_data      // Read data, registered
);

   localparam [AW:0] DEPTH_C = DEPTH;
   localparam [AW:0] ONE_C   = 1;

   reg  [WIDTH-1:0] mem [0:DEPTH-1];
   reg  [AW-1:0]    wr_ptr;
   reg  [AW-1:0]    rd_ptr;
   reg  [AW:0]      count;
   wire             push;
   wire             pop;

   assign o_ready = (count != DEPTH_C);
   assign push    = i_valid && o_ready;
   // The output register refills from a non-empty buffer whenever it is empty or being taken
   assign pop     = (count != {(AW+1){1'b0}}) && (!o_valid || i_ready);

   always @(posedge i_clk)
   begin
      if (i_ce && push)
         mem[wr_ptr] <= i_data;
   end

   always @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         wr_ptr  <= {AW{1'b0}};
         rd_ptr  <= {AW{1'b0}};
         count   <= {(AW+1){1'b0}};
         o_valid <= 1'b0;
         o_data  <= {WIDTH{1'b0}};
      end
      else if (i_ce)
      begin
         if (push)
            wr_ptr <= wr_ptr + 1'b1;
         if (pop)
         begin
            rd_ptr <= rd_ptr + 1'b1;
            o_data <= mem[rd_ptr];
         end
         if (push && !pop)
            count <= count + ONE_C;
         else if (pop && !push)
            count <= count - ONE_C;
         if (pop)
            o_valid <= 1'b1;
         else if (i_ready)
            o_valid <= 1'b0;
      end
   end

endmodule // cdi_fifo
`default_nettype wire

// ==== cdi_intake.v ====
/*
 Configuration data intake: strobed peripheral port, master parallel
 ROM addressing, serial input, serial/status output and the chained
 byte-wide mode. Bytes land in a buffer drained by the frame loader.
 Assumes the mode, the done level and the error pulse come from logic on
 i_mclk; all pins, the configuration clock included, are asynchronous and
 are sampled by i_mclk, which must run well above that clock.
*/
`timescale 1ns/1ns
`default_nettype none
`include "cdi_regs.vh"

module cdi_intake #(
   parameter EXT_ADDR = 1,                    // Extended-capacity variant
   parameter DEPTH    = `CDI_FIFO_DEPTH,      // Buffer depth in bytes
   parameter AW       = 5                     // Buffer address width
) (
   input  wire                      i_mclk,                  // Block clock
   input  wire                      i_rst_b,                 // Async reset, active low
   input  wire                      i_ce,                    // Clock enable
   input  wire [`CDI_MODE_W-1:0]    i_mode,                  // Configuration mode
   input  wire                      i_cfg_done,              // Configuration complete
   input  wire                      i_cfg_error,             // Data error pulse
   input  wire                      i_select_low_active_n,   // Chip select, active low
   input  wire                      i_select_high_active,    // Chip select / chained-mode enable
   input  wire                      i_write_strobe_n,        // Write strobe, active low
   input  wire                      i_read_strobe_n,         // Read strobe, active low
   input  wire                      i_cfg_clock,             // Configuration clock pin
   input  wire                      i_din,                   // Serial data, bit 0 in parallel
   input  wire [`CDI_BYTE_MSB:1]    i_data,                  // Data pins 1 to 7
   output reg  [`CDI_BYTE_MSB:0]    o_data,                  // Status byte out
   output wire                      o_data_oe_n,             // Data pins driven when low
   output reg  [`CDI_ADDR_W-1:0]    o_rom_address_out,       // ROM address
   output reg  [`CDI_ADDR_UP_W-1:0] o_rom_address_upper_out, // Upper ROM address
   output wire                      o_addr_oe_n,             // Address driven when low
   output reg                       o_dout,                  // Serial data or status
   output wire                      o_dout_oe_n,             // Serial output driven when low
   output wire                      o_init_n,                // Init pin value, always low
   output wire                      o_init_oe_n,             // Init pulled low when low
   output wire                      o_user_io,               // Pins released to user
   output wire                      o_busy,                  // Peripheral busy level
   output wire                      o_byte_valid,            // Byte to frame loader
   input  wire                      i_byte_ready,            // Frame loader takes byte
   output wire [`CDI_BYTE_MSB:0]    o_byte                   // Byte value
);

   localparam [`CDI_ADDR_W+`CDI_ADDR_UP_W-1:0] ADDR_ONE = `CDI_ADDR_ONE;

   reg                          rst_meta;
   reg                          rst_n;
   reg  [`CDI_PIN_W-1:0]        pin_meta;
   reg  [`CDI_PIN_W-1:0]        pin_s;
   reg                          clk_q;
   reg                          ws_q;
   reg  [`CDI_BYTE_MSB:0]       hold;
   reg                          hold_valid;
   reg  [`CDI_BYTE_MSB:0]       shift_in;
   reg  [`CDI_BIT_CNT_W-1:0]    bit_cnt;
   reg  [`CDI_BYTE_MSB:0]       shift_out;
   reg                          dout_stage;
   reg                          err_flag;
   reg  [`CDI_ADDR_W+`CDI_ADDR_UP_W-1:0] addr;
   wire                         mode_serial;
   wire                         mode_periph;
   wire                         mode_mpar;
   wire                         mode_express;
   wire                         active;
   wire                         selected;
   wire                         clk_rise;
   wire                         clk_fall;
   wire                         ws_fall;
   wire [`CDI_BYTE_MSB:0]       pin_byte;
   wire                         fifo_ready;
   wire                         par_take;
   wire                         ser_take;
   wire                         rd_req;
   reg  [`CDI_BYTE_MSB:0]       next_shift_in;

   // Reset is released through two flops, asserted at once
   always @(posedge i_mclk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end
      else
      begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   // Two-flop synchroniser for every pin; only pin_s is read by logic
   always @(posedge i_mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pin_meta <= {`CDI_PIN_W{1'b0}};
         pin_s    <= {`CDI_PIN_W{1'b0}};
      end
      else if (i_ce)
      begin
         pin_meta <= {i_data, i_din, i_cfg_clock, i_read_strobe_n,
                      i_write_strobe_n, i_select_high_active,
                      i_select_low_active_n};
         pin_s    <= pin_meta;
      end
   end

   assign mode_serial  = (i_mode == `CDI_MODE_SSER) || (i_mode == `CDI_MODE_MSER);
   assign mode_periph  = (i_mode == `CDI_MODE_PERIPH);
   assign mode_mpar    = (i_mode == `CDI_MODE_MPAR);
   assign mode_express = (i_mode == `CDI_MODE_EXPRESS);
   assign active       = !i_cfg_done;

   assign selected = !pin_s[`CDI_PIN_CS_LO] && pin_s[`CDI_PIN_CS_HI];
   assign clk_rise = pin_s[`CDI_PIN_CLK] && !clk_q;
   assign clk_fall = !pin_s[`CDI_PIN_CLK] && clk_q;
   assign ws_fall  = !pin_s[`CDI_PIN_WS] && ws_q;
   // Serial input doubles as bit 0 of the byte
   assign pin_byte = {pin_s[`CDI_PIN_D_HI:`CDI_PIN_D_LO], pin_s[`CDI_PIN_DIN]};

   // Parallel capture: peripheral strobe, master parallel or chained clock
   // edge. A clock edge that finds the holding byte still full is skipped,
   // so in master parallel mode the ROM address does not run ahead.
   assign par_take = active && !hold_valid && (
                     (mode_periph && selected && ws_fall) ||
                     (mode_mpar && clk_rise) ||
                     (mode_express && clk_rise && pin_s[`CDI_PIN_CS_HI]));
   assign ser_take = active && mode_serial && clk_rise;

   // Write strobe wins over read strobe
   assign rd_req = active && mode_periph && selected &&
                   !pin_s[`CDI_PIN_RS] && pin_s[`CDI_PIN_WS];

   always @*
   begin
      next_shift_in = {shift_in[`CDI_BYTE_MSB-1:0], pin_s[`CDI_PIN_DIN]};
   end

   always @(posedge i_mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         clk_q      <= 1'b0;
         ws_q       <= 1'b1;
         hold       <= `CDI_ZERO_BYTE;
         hold_valid <= 1'b0;
         shift_in   <= `CDI_ZERO_BYTE;
         bit_cnt    <= {`CDI_BIT_CNT_W{1'b0}};
         addr       <= {(`CDI_ADDR_W+`CDI_ADDR_UP_W){1'b0}};
      end
      else if (i_ce)
      begin
         clk_q <= pin_s[`CDI_PIN_CLK];
         ws_q  <= pin_s[`CDI_PIN_WS];
         if (hold_valid && fifo_ready)
            hold_valid <= 1'b0;
         if (par_take)
         begin
            hold       <= pin_byte;
            hold_valid <= 1'b1;
            if (mode_mpar)
               addr <= addr + ADDR_ONE;
         end
         // Serial bytes arrive MSB first; a full holding byte at the
         // eighth bit would lose data, so the feeder must pace itself
         if (ser_take)
         begin
            shift_in <= next_shift_in;
            bit_cnt  <= bit_cnt + 1'b1;
            if (bit_cnt == `CDI_BIT_LAST)
            begin
               hold       <= next_shift_in;
               hold_valid <= 1'b1;
            end
         end
      end
   end

   // Serial output path: a bit sampled on a rise reaches the pin on the
   // second fall after it, one and a half periods later
   always @(posedge i_mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         dout_stage <= 1'b0;
         shift_out  <= `CDI_ZERO_BYTE;
         o_dout     <= 1'b0;
      end
      else if (i_ce)
      begin
         if (mode_express)
            o_dout <= i_cfg_done;
         else if (clk_fall)
         begin
            o_dout <= dout_stage;
            // Take the bit caught on the last rise; the pin may already
            // carry the next bit by the time this fall is seen
            if (mode_serial)
               dout_stage <= shift_in[0];
            else
            begin
               dout_stage <= shift_out[`CDI_BYTE_MSB];
               shift_out  <= {shift_out[`CDI_BYTE_MSB-1:0], 1'b0};
            end
         end
         if (par_take && !mode_express)
            shift_out <= pin_byte;
      end
   end

   // Error is sticky for the rest of the session
   always @(posedge i_mclk or negedge rst_n)
   begin
      if (!rst_n)
         err_flag <= 1'b0;
      else if (i_ce && active && i_cfg_error)
         err_flag <= 1'b1;
   end

   // Status read: top bit ready, lower bits high
   always @(posedge i_mclk or negedge rst_n)
   begin
      if (!rst_n)
         o_data <= `CDI_ZERO_BYTE;
      else if (i_ce)
         o_data <= {!o_busy, `CDI_STATUS_FILL};
   end

   // Address outputs; the upper bits stay zero on the basic variant
   always @(posedge i_mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         o_rom_address_out       <= `CDI_ZERO_ADDR;
         o_rom_address_upper_out <= `CDI_ZERO_ADDR_UP;
      end
      else if (i_ce)
      begin
         o_rom_address_out <= addr[`CDI_ADDR_W-1:0];
         if (EXT_ADDR != 0)
            o_rom_address_upper_out <= addr[`CDI_ADDR_W+`CDI_ADDR_UP_W-1:`CDI_ADDR_W];
      end
   end

   assign o_busy      = hold_valid;
   assign o_data_oe_n = !rd_req;
   assign o_addr_oe_n = !(active && mode_mpar);
   assign o_dout_oe_n = !active;
   assign o_init_n    = 1'b0;
   assign o_init_oe_n = !(active && err_flag);
   assign o_user_io   = i_cfg_done;

   cdi_fifo #(
      .WIDTH (`CDI_BYTE_W),
      .DEPTH (DEPTH),
      .AW    (AW)
   ) u_fifo (
      .i_clk   (i_mclk),
      .i_rst_n (rst_n),
      .i_ce    (i_ce),
      .i_valid (hold_valid),
      .o_ready (fifo_ready),
      .i_data  (hold),
      .o_valid (o_byte_valid),
      .i_ready (i_byte_ready),
      .o_data  (o_byte)
   );

endmodule // cdi_intake
`default_nettype wire

// ==== cdi_intake_asserts.sv ====
/* Checker for cdi_intake: status byte, write timing, address, release and serial output.
 Assumes i_ce held high and pins slower than three block clocks. */
`timescale 1ns/1ns
`default_nettype none
module cdi_intake_asserts (
   input wire logic        i_mclk,                  // Clock
   input wire logic        i_rst_b,                 // Reset
   input wire logic [2:0]  i_mode,                  // Mode
   input wire logic        i_cfg_done,              // Done
   input wire logic        i_cfg_error,             // Error pulse
   input wire logic        i_select_low_active_n,   // Select low
   input wire logic        i_select_high_active,    // Select high
   input wire logic        i_write_strobe_n,        // Write strobe
   input wire logic        i_cfg_clock,             // Config clock
   input wire logic [7:0]  o_data,                  // Status byte
   input wire logic        o_data_oe_n,             // Data enable
   input wire logic [17:0] o_rom_address_out,       // Address
   input wire logic [3:0]  o_rom_address_upper_out, // Upper address
   input wire logic        o_addr_oe_n,             // Address enable
   input wire logic        o_dout,                  // Serial out
   input wire logic        o_dout_oe_n,             // Serial enable
   input wire logic        o_init_n,                // Init value
   input wire logic        o_init_oe_n,             // Init enable
   input wire logic        o_user_io,               // Released
   input wire logic        o_busy                   // Busy
);
   default clocking @(posedge i_mclk); endclocking
   default disable iff (!i_rst_b);
   wire [21:0] addr = {o_rom_address_upper_out, o_rom_address_out};
   property p_status; !o_data_oe_n |-> o_data == {!$past(o_busy), 7'h7f}; endproperty
   a_status: assert property (p_status) else $error("status byte wrong");
   property p_write; $fell(i_write_strobe_n) && !i_select_low_active_n && i_select_high_active
      && i_mode == 3'h2 && !i_cfg_done && !o_busy |-> ##[1:4] o_busy; endproperty
   a_write: assert property (p_write) else $error("write not taken");
   property p_rel; i_cfg_done |-> o_data_oe_n && o_addr_oe_n && o_dout_oe_n && o_init_oe_n && o_user_io; endproperty
   a_rel: assert property (p_rel) else $error("pins not released");
   property p_aoe; o_addr_oe_n == (i_mode != 3'h3 || i_cfg_done); endproperty
   a_aoe: assert property (p_aoe) else $error("address enable wrong");
   property p_step; i_mode == 3'h3 && $changed(addr) |-> addr == $past(addr) + 22'h1; endproperty
   a_step: assert property (p_step) else $error("address step wrong");
   property p_ierr; i_cfg_error && !i_cfg_done |-> ##[0:3] !o_init_oe_n; endproperty
   a_ierr: assert property (p_ierr) else $error("init not pulled");
   property p_ihold; !o_init_oe_n ##1 !i_cfg_done |-> !o_init_oe_n && !o_init_n; endproperty
   a_ihold: assert property (p_ihold) else $error("init dropped");
   property p_chain; (i_mode == 3'h4 && !i_cfg_done) [*3] |-> !o_dout; endproperty
   a_chain: assert property (p_chain) else $error("chain status wrong");
   property p_fall; i_mode <= 3'h1 && !i_cfg_done && $changed(o_dout)
      |-> !$past(i_cfg_clock, 2) || !$past(i_cfg_clock, 3); endproperty
   a_fall: assert property (p_fall) else $error("serial out off fall");
endmodule // cdi_intake_asserts
bind cdi_intake cdi_intake_asserts u_chk (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_mode(i_mode),
   .i_cfg_done(i_cfg_done), .i_cfg_error(i_cfg_error), .i_select_low_active_n(i_select_low_active_n),
   .i_select_high_active(i_select_high_active), .i_write_strobe_n(i_write_strobe_n),
   .i_cfg_clock(i_cfg_clock), .o_data(o_data), .o_data_oe_n(o_data_oe_n), .o_rom_address_out(o_rom_address_out),
   .o_rom_address_upper_out(o_rom_address_upper_out), .o_addr_oe_n(o_addr_oe_n), .o_dout(o_dout),
   .o_dout_oe_n(o_dout_oe_n), .o_init_n(o_init_n), .o_init_oe_n(o_init_oe_n), .o_user_io(o_user_io),
   .o_busy(o_busy));
`default_nettype wire

// ==== cdi_host_model.sv ====
/* Partner model: peripheral host, configuration ROM and upstream feeder.
 Assumes one task at a time and that the bench resolves the data pins. */
`timescale 1ns/1ns
`default_nettype none
module cdi_host (
   input  wire logic        i_mclk,      // Clock
   input  wire logic [7:0]  i_data,      // Data pins
   input  wire logic        i_data_oe_n, // Device drives
   input  wire logic [17:0] i_rom_addr,  // ROM address
   input  wire logic        i_dout,      // Serial out
   output var  logic        o_sel_lo_n,  // Select low
   output var  logic        o_sel_hi,    // Select high
   output var  logic        o_ws_n,      // Write strobe
   output var  logic        o_rs_n,      // Read strobe
   output var  logic        o_cfg_clock,      // Config clock
   output var  logic [7:0]  o_d          // Data, bit 0 serial
);
   logic       rom_on = 1'b0;
   logic [7:0] collide = 8'h00;
   logic [7:0] dout_bad = 8'h00;
   initial
   begin
      {o_sel_lo_n, o_sel_hi, o_ws_n, o_rs_n, o_cfg_clock} = 5'h16;
      o_d = 8'h00;
   end
   always @(posedge i_mclk)
   begin
      if (rom_on)
         o_d <= i_rom_addr[7:0] ^ 8'ha5;
      if (!o_ws_n && !i_data_oe_n)
         collide <= collide + 8'h01;
   end
   // Polls ready first; a busy device is never written
   task automatic pw(input logic [7:0] b, input logic rd, sl, sh, output logic ok);
      ok = 1'b0;
      for (int k = 0; k < 40 && !ok; k++)
      begin
         @(posedge i_mclk) {o_sel_lo_n, o_sel_hi, o_rs_n} <= 3'h2;
         repeat (6) @(posedge i_mclk);
         ok = !i_data_oe_n && i_data[7];
         o_rs_n <= 1'b1;
         repeat (3) @(posedge i_mclk);
      end
      if (ok)
      begin
         {o_sel_lo_n, o_sel_hi, o_d} <= {sl, sh, b};
         @(posedge i_mclk) {o_ws_n, o_rs_n} <= {1'b0, !rd};
         repeat (4) @(posedge i_mclk);
         {o_ws_n, o_rs_n} <= 2'h3;
         repeat (3) @(posedge i_mclk) {o_sel_lo_n, o_sel_hi, o_d} <= {2'h2, ~b};
         repeat (4) @(posedge i_mclk);
      end
   endtask
   // Clock runs only inside the frame
   task automatic ser(input logic [7:0] q[$]);
      logic h[$];
      foreach (q[j])
         for (int n = 7; n >= 0; n--)
            h.push_back(q[j][n]);
      @(posedge i_mclk) #1;
      foreach (h[j])
      begin
         o_d[0] = h[j];
         #24 o_cfg_clock = 1'b1;
         if (j >= 2 && i_dout !== h[j-2])
            dout_bad = dout_bad + 8'h01;
         #24 o_cfg_clock = 1'b0;
      end
      o_d[0] = ~o_d[0];
   endtask
   task automatic cyc(input logic [7:0] b, input logic en);
      @(posedge i_mclk) #1;
      o_sel_hi = en;
      if (!rom_on)
         o_d = b;
      #24 o_cfg_clock = 1'b1;
      #24 o_cfg_clock = 1'b0;
      if (!rom_on)
         o_d = ~b;
   endtask
endmodule // cdi_host
`default_nettype wire

// ==== test_config_data_intake_ports.sv ====
/* Self-checking bench for cdi_intake.
 Assumes the host model and the bound checker are compiled first. */
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin err_total++; \
   $display("[ERR] %s expected %h seen %h", nm, ex, got); end end
module test_config_data_intake_ports;
   logic mclk = 1'b0, rst_b = 1'b0, done = 1'b0, err_p = 1'b0, stall = 1'b0, brdy = 1'b0, ok;
   logic [2:0] mode = 3'h2;
   logic [7:0] b, exp_q[$], got_q[$], q[$];
   int err_total = 0, tests_run = 0, seed = 2543, i, k;
   wire sl_n, sh, ws_n, rs_n, cfg_clock, doe_n, aoe_n, dout, dooe_n, init_n, ioe_n, uio, busy, bval;
   wire [7:0] hd, od, ob;
   wire [17:0] addr;
   wire [3:0] aup;
   wire [7:0] pins = doe_n ? hd : od;
   always #2 mclk = ~mclk;
   always @(posedge mclk)
   begin
      brdy <= !stall && ($random(seed) % 3 != 0);
      if (bval && brdy)
         got_q.push_back(ob);
   end
   cdi_intake DUT (.i_mclk(mclk), .i_rst_b(rst_b), .i_ce(1'b1), .i_mode(mode), .i_cfg_done(done),
      .i_cfg_error(err_p), .i_select_low_active_n(sl_n), .i_select_high_active(sh),
      .i_write_strobe_n(ws_n), .i_read_strobe_n(rs_n), .i_cfg_clock(cfg_clock), .i_din(pins[0]),
      .i_data(pins[7:1]), .o_data(od), .o_data_oe_n(doe_n), .o_rom_address_out(addr),
      .o_rom_address_upper_out(aup), .o_addr_oe_n(aoe_n), .o_dout(dout), .o_dout_oe_n(dooe_n),
      .o_init_n(init_n), .o_init_oe_n(ioe_n), .o_user_io(uio), .o_busy(busy),
      .o_byte_valid(bval), .i_byte_ready(brdy), .o_byte(ob));
   cdi_host u_host (.i_mclk(mclk), .i_data(pins), .i_data_oe_n(doe_n), .i_rom_addr(addr),
      .i_dout(dout), .o_sel_lo_n(sl_n), .o_sel_hi(sh), .o_ws_n(ws_n), .o_rs_n(rs_n),
      .o_cfg_clock(cfg_clock), .o_d(hd));
   function automatic logic [7:0] rom_byte(input logic [17:0] a);
      return a[7:0] ^ 8'ha5;
   endfunction
   task automatic complete_run;
      if (err_total == 0 && tests_run > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic wr(input logic [7:0] v, input logic rd);
      logic okw;
      u_host.pw(v, rd, 1'b0, 1'b1, okw);
      exp_q.push_back(v);
      if (!okw)
      begin
         err_total++;
         complete_run();
      end
   endtask
   // Extra wait catches bytes that should never have arrived
   task automatic flush(input string nm);
      int n;
      logic [7:0] e, g;
      for (n = 0; n < 3000 && got_q.size() < exp_q.size(); n++)
         @(posedge mclk);
      repeat (20) @(posedge mclk);
      `CHK(nm, exp_q.size(), got_q.size())
      while (exp_q.size() > 0 && got_q.size() > 0)
      begin
         e = exp_q.pop_front();
         g = got_q.pop_front();
         `CHK(nm, e, g)
      end
      exp_q = {};
      got_q = {};
      if (n == 3000)
         complete_run();
   endtask
   initial
   begin
      repeat (20) @(posedge mclk);
      rst_b <= 1'b1;
      repeat (8) @(posedge mclk);
      for (i = 0; i < 8; i++)
         wr(i == 0 ? 8'h00 : i == 1 ? 8'hff : 8'($random(seed)), i == 3);
      flush("peripheral bytes");
      `CHK("read during write", 8'h00, u_host.collide)
      for (i = 0; i < 3; i++)
         u_host.pw(8'h3c, 1'b0, i != 1, i == 0, ok);
      flush("deselected write");
      stall <= 1'b1;
      k = 0;
      ok = 1'b1;
      while (ok && k < 40)
      begin
         b = 8'(k * 7);
         u_host.pw(b, 1'b0, 1'b0, 1'b1, ok);
         if (ok)
         begin
            exp_q.push_back(b);
            k++;
         end
      end
      `CHK("fill refused", 1'b1, k > 32 && k < 40)
      `CHK("busy while full", 1'b1, busy)
      stall <= 1'b0;
      flush("drained bytes");
      `CHK("ready after drain", 1'b0, busy)
      for (i = 0; i < 2; i++)
      begin
         mode <= 3'(i);
         q = {8'h80, 8'h01, 8'($random(seed)), 8'($random(seed))};
         repeat (4) @(posedge mclk);
         u_host.ser(q);
         exp_q = q;
         flush("serial bytes");
      end
      `CHK("serial echo slips", 8'h00, u_host.dout_bad)
      mode <= 3'h3;
      @(negedge mclk) u_host.rom_on = 1'b1;
      repeat (4) @(posedge mclk);
      for (i = 0; i < 6; i++)
      begin
         exp_q.push_back(rom_byte(18'(i)));
         u_host.cyc(8'h00, 1'b1);
      end
      flush("rom bytes");
      `CHK("rom address", 22'h6, {aup, addr})
      `CHK("address driven", 1'b0, aoe_n)
      @(negedge mclk) u_host.rom_on = 1'b0;
      mode <= 3'h4;
      repeat (4) @(posedge mclk);
      for (i = 0; i < 6; i++)
      begin
         b = 8'($random(seed));
         if (i % 3 != 1)
            exp_q.push_back(b);
         u_host.cyc(b, i % 3 != 1);
         `CHK("chain status", 1'b0, dout)
      end
      flush("chained bytes");
      err_p <= 1'b1;
      @(posedge mclk) err_p <= 1'b0;
      repeat (4) @(posedge mclk);
      `CHK("init pulled", 1'b0, ioe_n)
      done <= 1'b1;
      repeat (3) @(posedge mclk);
      `CHK("pins released", 5'h1f, {uio, ioe_n, doe_n, aoe_n, dooe_n})
      complete_run();
   end
endmodule // test_config_data_intake_ports
`default_nettype wire
